/* idj_exec.sv */
// Purpose: executes the inc/dec-with-skip, increment and absolute jump ops
// Assumes: a new instruction word is presented for every Q1; the second
//          jump word is presented by Q4 of the jump's first cycle
// Notes: file memory, fetch, W and the program counter live outside
`timescale 1ns/1ps

// Notes on behaviour
// - With the destination bit at 0 the result goes to the working register.
// - With destination bit 1 the result goes back to the file register.
// - Increment-skip-on-zero flushes the next instruction on a zero result.
// - Increment-skip-on-nonzero flushes the next instruction if nonzero.
// - A taken skip adds one no-operation cycle, two cycles in all.
// - Skipping a two-word instruction adds two no-op cycles, three in all.
// - Access bit 0 picks the fixed access bank and ignores the bank value.
// - Access bit 1 forms the address from the bank value and the file field.
// - The jump loads its 20-bit literal into PC bits 20:1 with bit 0 clear.
// - The jump always takes two cycles, the second a no-operation.
// - The jump reaches any word of the full program space without paging.
module idj_exec #(
   parameter int DATA_W = 8,
   parameter int BANK_W = 4,
   parameter int PC_W = 21
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [15:0] instr_word,
   input wire logic next_two_word,
   input wire logic [BANK_W-1:0] bank_select_value,
   input wire logic [DATA_W-1:0] file_rd_data,
   output logic [1:0] q_phase,
   output logic [BANK_W+DATA_W-1:0] file_addr,
   output logic file_wr_en,
   output logic w_wr_en,
   output logic [DATA_W-1:0] result_data,
   output logic flags_wr_en,
   output logic [4:0] flags,
   output logic pc_load_en,
   output logic [PC_W-1:0] pc_load_value,
   output logic skip_flush,
   output logic cycle_done
);
   typedef struct packed {
      logic [1:0] phase;
      idj_pkg::idj_mode_t mode;
      logic [1:0] nop_left;
      idj_pkg::idj_op_t op;
      logic dst_f;
      logic [BANK_W+DATA_W-1:0] addr;
      logic [DATA_W-1:0] k_lo;
      logic [DATA_W-1:0] res;
      logic [4:0] flg;
      logic file_wr_en;
      logic w_wr_en;
      logic flags_wr_en;
      logic pc_load_en;
      logic [PC_W-1:0] pc_value;
      logic skip_flush;
      logic cycle_done;
   } idj_state_t;

   idj_state_t state_reg;
   idj_state_t state_next;

   // opcode decode, shared by the phase logic and the checks
   function automatic idj_pkg::idj_op_t decode_op(input logic [15:0] w);
      idj_pkg::idj_op_t o;
      o = idj_pkg::IDJ_OP_NONE;
      if (w[15:8] == idj_pkg::PFX_JUMP) begin
         o = idj_pkg::IDJ_OP_JUMP;
      end else if (w[15:10] == idj_pkg::PFX_DEC_SZ) begin
         o = idj_pkg::IDJ_OP_DEC_SZ;
      end else if (w[15:10] == idj_pkg::PFX_DEC_SNZ) begin
         o = idj_pkg::IDJ_OP_DEC_SNZ;
      end else if (w[15:10] == idj_pkg::PFX_INC) begin
         o = idj_pkg::IDJ_OP_INC;
      end else if (w[15:10] == idj_pkg::PFX_INC_SZ) begin
         o = idj_pkg::IDJ_OP_INC_SZ;
      end else if (w[15:10] == idj_pkg::PFX_INC_SNZ) begin
         o = idj_pkg::IDJ_OP_INC_SNZ;
      end
      return o;
   endfunction

   // read-modify-write ops: everything but the jump and unknown opcodes
   function automatic logic is_rmw(input idj_pkg::idj_op_t o);
      return (o != idj_pkg::IDJ_OP_NONE) && (o != idj_pkg::IDJ_OP_JUMP);
   endfunction

   // operand address; access bank split keeps low page and top SFR page
   function automatic logic [BANK_W+DATA_W-1:0] form_addr(
      input logic acc, input logic [DATA_W-1:0] f,
      input logic [BANK_W-1:0] bank);
      logic [BANK_W-1:0] b;
      b = bank;
      if (!acc) begin
         b = f[idj_pkg::ACC_SPLIT_BIT] ? idj_pkg::ACC_HIGH_BANK
                                       : idj_pkg::ACC_LOW_BANK;
      end
      return {b, f};
   endfunction

   // skip decision from op and result
   function automatic logic skip_taken(input idj_pkg::idj_op_t o,
                                       input logic [DATA_W-1:0] r);
      logic z;
      z = (r == idj_pkg::ZERO_8);
      return ((o == idj_pkg::IDJ_OP_INC_SZ || o == idj_pkg::IDJ_OP_DEC_SZ)
              && z)
          || ((o == idj_pkg::IDJ_OP_INC_SNZ || o == idj_pkg::IDJ_OP_DEC_SNZ)
              && !z);
   endfunction

   // next state: one phase per clock, work happens on fixed phases
   always_comb begin
      logic [DATA_W:0] sum;
      logic is_dec;
      logic [DATA_W-1:0] d;
      sum = '0;
      is_dec = 1'b0;
      d = file_rd_data;
      state_next = state_reg;
      state_next.phase = state_reg.phase + 2'h1;
      state_next.file_wr_en = 1'b0;
      state_next.w_wr_en = 1'b0;
      state_next.flags_wr_en = 1'b0;
      state_next.pc_load_en = 1'b0;
      state_next.cycle_done = 1'b0;
      case (state_reg.mode)
         idj_pkg::IDJ_EXEC: begin
            case (state_reg.phase)
               idj_pkg::Q1: begin
                  state_next.op = decode_op(instr_word);
                  state_next.dst_f = instr_word[idj_pkg::DEST_BIT];
                  state_next.k_lo = instr_word[7:0];
                  state_next.addr = form_addr(
                     instr_word[idj_pkg::ACC_BIT], instr_word[7:0],
                     bank_select_value);
               end
               idj_pkg::Q3: begin
                  // operand read during Q2, processed here
                  is_dec = (state_reg.op == idj_pkg::IDJ_OP_DEC_SZ) ||
                           (state_reg.op == idj_pkg::IDJ_OP_DEC_SNZ);
                  if (is_dec) begin
                     state_next.res = d - idj_pkg::ONE_8;
                  end else begin
                     sum = {1'b0, d} + {1'b0, idj_pkg::ONE_8};
                     state_next.res = sum[DATA_W-1:0];
                  end
                  // flag word is on the flags port for every op, but flags_wr_en is set only for plain increment
                  state_next.flg[idj_pkg::FLG_C] = sum[DATA_W];
                  state_next.flg[idj_pkg::FLG_DC] =
                     (d[3:0] == idj_pkg::NIB_FULL);
                  state_next.flg[idj_pkg::FLG_N] = sum[DATA_W-1];
                  state_next.flg[idj_pkg::FLG_OV] =
                     (d == idj_pkg::MAX_POS_8);
                  state_next.flg[idj_pkg::FLG_Z] =
                     (sum[DATA_W-1:0] == idj_pkg::ZERO_8);
               end
               idj_pkg::Q4: begin
                  state_next.cycle_done = 1'b1;
                  if (is_rmw(state_reg.op)) begin
                     state_next.file_wr_en = state_reg.dst_f;
                     state_next.w_wr_en = !state_reg.dst_f;
                     state_next.flags_wr_en =
                        (state_reg.op == idj_pkg::IDJ_OP_INC);
                  end
                  if (skip_taken(state_reg.op, state_reg.res)) begin
                     state_next.mode = idj_pkg::IDJ_NOP;
                     state_next.skip_flush = 1'b1;
                     state_next.nop_left = next_two_word
                        ? idj_pkg::NOPS_TWO_WORD
                        : idj_pkg::NOPS_ONE_WORD;
                  end else if (state_reg.op == idj_pkg::IDJ_OP_JUMP) begin
                     // full 21-bit PC, no page bits kept
                     state_next.pc_load_en = 1'b1;
                     state_next.pc_value =
                        {instr_word[11:0], state_reg.k_lo, 1'b0};
                     state_next.mode = idj_pkg::IDJ_NOP;
                     state_next.skip_flush = 1'b1;
                     state_next.nop_left = idj_pkg::NOPS_JUMP;
                  end
               end
               default: begin
               end
            endcase
         end
         idj_pkg::IDJ_NOP: begin
            // words fetched meanwhile are discarded, nothing written
            if (state_reg.phase == idj_pkg::Q4) begin
               state_next.cycle_done = 1'b1;
               state_next.nop_left = state_reg.nop_left - 2'h1;
               if (state_reg.nop_left == idj_pkg::NOPS_ONE_WORD) begin
                  state_next.mode = idj_pkg::IDJ_EXEC;
                  state_next.skip_flush = 1'b0;
               end
            end
         end
         default: begin
            state_next.mode = idj_pkg::IDJ_EXEC;
         end
      endcase
   end

   // single state register
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   assign q_phase = state_reg.phase;
   assign file_addr = state_reg.addr;
   assign file_wr_en = state_reg.file_wr_en;
   assign w_wr_en = state_reg.w_wr_en;
   assign result_data = state_reg.res;
   assign flags_wr_en = state_reg.flags_wr_en;
   assign flags = state_reg.flg;
   assign pc_load_en = state_reg.pc_load_en;
   assign pc_load_value = state_reg.pc_value;
   assign skip_flush = state_reg.skip_flush;
   assign cycle_done = state_reg.cycle_done;

   // checks on the block's own outputs
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   w_dest_only_a: assert property (
      w_wr_en |-> !state_reg.dst_f && !file_wr_en && is_rmw(state_reg.op))
      else $error("working register written with destination bit set");

   file_dest_only_a: assert property (
      file_wr_en |-> state_reg.dst_f && $past(state_reg.phase == 2'h3))
      else $error("file written without destination bit or off phase");

   inc_zero_skip_a: assert property (
      (state_reg.mode == idj_pkg::IDJ_EXEC && state_reg.phase == 2'h3 &&
       state_reg.op == idj_pkg::IDJ_OP_INC_SZ && state_reg.res == 8'h00)
      |=> skip_flush && cycle_done)
      else $error("zero result did not skip");

   inc_nz_skip_a: assert property (
      (state_reg.mode == idj_pkg::IDJ_EXEC && state_reg.phase == 2'h3 &&
       state_reg.op == idj_pkg::IDJ_OP_INC_SNZ)
      |=> skip_flush == (result_data != 8'h00))
      else $error("nonzero skip decision wrong");

   one_nop_len_a: assert property (
      ($rose(skip_flush) && state_reg.nop_left == 2'h1)
      |-> skip_flush[*4] ##1 !skip_flush)
      else $error("single no-op cycle has wrong length");

   two_nop_len_a: assert property (
      ($rose(skip_flush) && state_reg.nop_left == 2'h2)
      |-> skip_flush[*8] ##1 !skip_flush)
      else $error("double no-op cycle has wrong length");

   access_bank_a: assert property (
      (state_reg.mode == idj_pkg::IDJ_EXEC && state_reg.phase == 2'h0 &&
       !instr_word[8] && is_rmw(decode_op(instr_word)))
      |=> file_addr[11:8] == (file_addr[7] ? 4'hF : 4'h0)
          && file_addr[7:0] == $past(instr_word[7:0]))
      else $error("access bank address wrong");

   banked_addr_a: assert property (
      (state_reg.mode == idj_pkg::IDJ_EXEC && state_reg.phase == 2'h0 &&
       instr_word[8] && is_rmw(decode_op(instr_word)))
      |=> file_addr == {$past(bank_select_value), $past(instr_word[7:0])})
      else $error("banked address wrong");

   jump_target_a: assert property (
      pc_load_en |-> !pc_load_value[0] &&
         pc_load_value[8:1] == state_reg.k_lo &&
         pc_load_value[20:9] == $past(instr_word[11:0]))
      else $error("jump target not placed at bits 20:1");

   jump_two_cyc_a: assert property (
      pc_load_en |-> skip_flush[*4] ##1 !skip_flush)
      else $error("jump did not take exactly one no-op cycle");

   flags_inc_only_a: assert property (
      flags_wr_en |-> state_reg.op == idj_pkg::IDJ_OP_INC &&
         flags[idj_pkg::FLG_Z] == (result_data == idj_pkg::ZERO_8))
      else $error("flags written by a skip op or zero flag wrong");

   // refusals and mutually exclusive strobes
   unknown_quiet_a: assert property (
      (file_wr_en || w_wr_en || skip_flush)
      |-> state_reg.op != idj_pkg::IDJ_OP_NONE)
      else $error("unknown opcode wrote or skipped");

   nop_no_write_a: assert property (
      state_reg.mode == idj_pkg::IDJ_NOP
      |=> !file_wr_en && !w_wr_en && !flags_wr_en && !pc_load_en)
      else $error("substituted no-operation wrote a result");

   jump_only_pc_a: assert property (
      pc_load_en |-> state_reg.op == idj_pkg::IDJ_OP_JUMP &&
         !file_wr_en && !w_wr_en && !flags_wr_en)
      else $error("program counter loaded by a non-jump op");
endmodule

/* idj_exec_tb.sv */
// Purpose: self-checking bench for the inc/dec skip and jump block
// Assumes: one instruction per four clocks, driver syncs on q_phase
// Notes: expectations go to a queue, a monitor pops them at cycle_done
`timescale 1ns/1ps
module inc_dec_skip_and_jump_exec_tb_top;
   typedef struct {
      logic fw, ww, fl, pc, chk;
      int nops;
      logic [7:0] res;
      logic [11:0] addr;
      logic [4:0] flg;
      logic [20:0] pcv;
   } idj_tb_exp_t;
   localparam int CYCLE_LIMIT = 2000;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic [15:0] instr_word = 16'h0000;
   logic next_two_word = 1'b0;
   logic [3:0] bank_select_value = 4'h0;
   logic [7:0] file_rd_data = 8'h00;
   logic [1:0] q_phase;
   logic [11:0] file_addr;
   logic file_wr_en, w_wr_en, flags_wr_en, pc_load_en;
   logic skip_flush, cycle_done;
   logic [7:0] result_data;
   logic [4:0] flags;
   logic [20:0] pc_load_value;
   idj_tb_exp_t exp_q[$];
   idj_tb_exp_t mon_e;
   int fail_count = 0;
   int checked = 0;
   int cycles = 0;
   int last_nops = 0;
   int run = 0;
   logic prev_skip = 1'b0;
   logic [31:0] lfsr = 32'hBAD8;

   idj_exec i_idj_exec (.sys_clk(sys_clk), .srst(srst),
      .instr_word(instr_word), .next_two_word(next_two_word),
      .bank_select_value(bank_select_value), .file_rd_data(file_rd_data),
      .q_phase(q_phase), .file_addr(file_addr), .file_wr_en(file_wr_en),
      .w_wr_en(w_wr_en), .result_data(result_data),
      .flags_wr_en(flags_wr_en), .flags(flags), .pc_load_en(pc_load_en),
      .pc_load_value(pc_load_value), .skip_flush(skip_flush),
      .cycle_done(cycle_done));

   // 50 MHz clock
   always #10 sys_clk = ~sys_clk;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // waits for a live Q1, skip cycles get random words that must be ignored
   task automatic run_op(input logic [15:0] w1, input logic [15:0] w2,
      input logic [7:0] rd, input logic [3:0] b, input logic nxt,
      input idj_tb_exp_t e);
      int n;
      n = 0;
      while (n < 40) begin
         @(posedge sys_clk);
         #1;
         if (q_phase === 2'h0 && skip_flush === 1'b0)
            break;
         lfsr = lfsr_next(lfsr);
         instr_word = lfsr[15:0];
         n++;
      end
      instr_word = w1;
      file_rd_data = rd;
      bank_select_value = b;
      next_two_word = nxt;
      repeat (3) begin
         @(posedge sys_clk);
         #1;
      end
      // second jump word must sit on the bus by the Q4 edge
      instr_word = w2;
      exp_q.push_back(e);
   endtask

   // reference for one read-modify-write op
   function automatic idj_tb_exp_t model(input int op, input logic d,
      input logic a, input logic [3:0] b, input logic [7:0] f,
      input logic [7:0] v, input logic nxt);
      idj_tb_exp_t e;
      logic [7:0] r;
      logic z, sk;
      r = (op < 2) ? v - 8'h01 : v + 8'h01;
      z = (r == 8'h00);
      sk = ((op == 0 || op == 3) && z) || ((op == 1 || op == 4) && !z);
      e.fw = d;
      e.ww = !d;
      e.fl = (op == 2);
      e.pc = 1'b0;
      e.chk = 1'b1;
      e.nops = sk ? (nxt ? 2 : 1) : 0;
      e.res = r;
      e.addr = a ? {b, f} : {(f[7] ? idj_pkg::ACC_HIGH_BANK :
                                     idj_pkg::ACC_LOW_BANK), f};
      e.flg = {r[7], v == 8'h7F, z, v[3:0] == 4'hF, v == 8'hFF};
      e.pcv = 21'h000000;
      return e;
   endfunction

   // monitor: nop cycles also end in cycle_done, so only count a pulse
   // that follows a cycle without skip_flush
   always @(posedge sys_clk) begin
      #2;
      if (srst === 1'b0) begin
         if (skip_flush === 1'b1)
            run++;
         else if (prev_skip === 1'b1) begin
            check("skip_cycles", run, 4 * last_nops);
            run = 0;
         end
         if (cycle_done === 1'b1 && prev_skip !== 1'b1 && exp_q.size() > 0)
         begin
            mon_e = exp_q.pop_front();
            last_nops = mon_e.nops;
            check("file_wr_en", file_wr_en, mon_e.fw);
            check("w_wr_en", w_wr_en, mon_e.ww);
            check("flags_wr_en", flags_wr_en, mon_e.fl);
            check("pc_load_en", pc_load_en, mon_e.pc);
            check("skip_flush", skip_flush, mon_e.nops > 0);
            if (mon_e.chk) begin
               check("result_data", result_data, mon_e.res);
               check("file_addr", file_addr, mon_e.addr);
            end
            if (mon_e.fl)
               check("flags", flags, mon_e.flg);
            if (mon_e.pc)
               check("pc_load_value", pc_load_value, mon_e.pcv);
         end
         prev_skip = skip_flush;
      end
   end

   // hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == CYCLE_LIMIT) begin
         fail_count++;
         $display("Error timeout expected done seen running");
         end_sim();
      end
   end

   initial begin
      logic [5:0] pfx [5];
      logic [7:0] v, f;
      logic nxt;
      logic [19:0] k;
      idj_tb_exp_t e;
      pfx[0] = idj_pkg::PFX_DEC_SZ;
      pfx[1] = idj_pkg::PFX_DEC_SNZ;
      pfx[2] = idj_pkg::PFX_INC;
      pfx[3] = idj_pkg::PFX_INC_SZ;
      pfx[4] = idj_pkg::PFX_INC_SNZ;
      repeat (8) @(posedge sys_clk);
      #1 srst = 1'b0;
      // every op, boundary operands, all d/a combinations
      for (int op = 0; op < 5; op++) begin
         for (int j = 0; j < 6; j++) begin
            lfsr = lfsr_next(lfsr);
            case (j)
               0: v = 8'hFF;
               1: v = 8'h00;
               2: v = 8'h01;
               3: v = 8'h7F;
               4: v = 8'h0F;
               default: v = lfsr[23:16];
            endcase
            f = (j == 1) ? 8'h80 : lfsr[11:4];
            // pin the two-word flag at j 0 and 2, where each skip op skips at one of them: both lengths run
            nxt = (j == 0) ? 1'b1 : (j == 2) ? 1'b0 : lfsr[12];
            e = model(op, j[0], j[1], lfsr[3:0], f, v, nxt);
            run_op({pfx[op], j[0], j[1], f}, lfsr[31:16], v, lfsr[3:0],
                   nxt, e);
         end
      end
      $display("test inc_dec_skip done");
      // jumps to both ends of program space and a random target
      for (int j = 0; j < 3; j++) begin
         lfsr = lfsr_next(lfsr);
         k = (j == 0) ? 20'h00000 : (j == 1) ? 20'hFFFFF : lfsr[19:0];
         e = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1, 8'h00, 12'h000, 5'h00,
               {k, 1'b0}};
         run_op({idj_pkg::PFX_JUMP, k[7:0]}, {idj_pkg::PFX_JUMP_2ND,
                k[19:8]}, 8'h00, lfsr[7:4], 1'b1, e);
      end
      $display("test absolute_jump done");
      // unknown opcode writes nothing and skips nothing
      e = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 0, 8'h00, 12'h000, 5'h00,
            21'h000000};
      run_op(16'h0000, 16'h0000, 8'h55, 4'h3, 1'b1, e);
      $display("test unknown_opcode done");
      repeat (16) @(posedge sys_clk);
      check("queue_empty", exp_q.size(), 0);
      end_sim();
   end
endmodule

/* idj_pkg.sv */
// Purpose: shared constants for the inc/dec skip and jump execution block
// Assumes: 16-bit instruction words, four sys_clk phases per instruction
// Notes: opcode prefixes are the upper six bits of the first word, the upper eight for the jump
package idj_pkg;
   // instruction phases, one sys_clk each
   localparam logic [1:0] Q1 = 2'h0;
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q3 = 2'h2;
   localparam logic [1:0] Q4 = 2'h3;
   // opcode prefixes, bits 15:10
   localparam logic [5:0] PFX_DEC_SZ = 6'h0B;
   localparam logic [5:0] PFX_DEC_SNZ = 6'h13;
   localparam logic [5:0] PFX_INC = 6'h0A;
   localparam logic [5:0] PFX_INC_SZ = 6'h0F;
   localparam logic [5:0] PFX_INC_SNZ = 6'h12;
   // absolute jump: first word prefix bits 15:8, second word bits 15:12
   localparam logic [7:0] PFX_JUMP = 8'hEF;
   localparam logic [3:0] PFX_JUMP_2ND = 4'hF;
   // field positions in the first word
   localparam int DEST_BIT = 9;
   localparam int ACC_BIT = 8;
   // fixed access bank: low half from bank 0, high half from bank 15
   localparam logic [3:0] ACC_LOW_BANK = 4'h0;
   localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
   localparam int ACC_SPLIT_BIT = 7;
   // flag bit positions in the flag word
   localparam int FLG_C = 0;
   localparam int FLG_DC = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_OV = 3;
   localparam int FLG_N = 4;
   // data constants
   localparam logic [7:0] ONE_8 = 8'h01;
   localparam logic [7:0] ZERO_8 = 8'h00;
   localparam logic [7:0] MAX_POS_8 = 8'h7F;
   localparam logic [3:0] NIB_FULL = 4'hF;
   // substituted no-operation cycles after a skip or a jump
   localparam logic [1:0] NOPS_ONE_WORD = 2'h1;
   localparam logic [1:0] NOPS_TWO_WORD = 2'h2;
   localparam logic [1:0] NOPS_JUMP = 2'h1;
   typedef enum logic [2:0] {
      IDJ_OP_NONE, IDJ_OP_DEC_SZ, IDJ_OP_DEC_SNZ, IDJ_OP_INC,
      IDJ_OP_INC_SZ, IDJ_OP_INC_SNZ, IDJ_OP_JUMP
   } idj_op_t;
   typedef enum logic {IDJ_EXEC, IDJ_NOP} idj_mode_t;
endpackage
